/* File: sut_defs.svh */
`ifndef SUT_DEFS_SVH
`define SUT_DEFS_SVH

// Register byte offsets
`define SUT_OFS_MODE       12'h000
`define SUT_OFS_BITRATE    12'h004
`define SUT_OFS_CTRL       12'h008
`define SUT_OFS_TXDATA     12'h00C
`define SUT_OFS_STATUS     12'h010
`define SUT_OFS_RXDATA     12'h014

// control_reg fields
`define SUT_CR_TXE_IE      7
`define SUT_CR_RX_IE       6
`define SUT_CR_TX_ON       5
`define SUT_CR_RX_ON       4
`define SUT_CR_MP_IE       3
`define SUT_CR_TXD_IE      2
`define SUT_CR_CLK_EXT     1

// status_reg fields
`define SUT_SR_TX_EMPTY    7
`define SUT_SR_RX_FULL     6
`define SUT_SR_OVERRUN     5
`define SUT_SR_FRAMING     4
`define SUT_SR_PARITY      3
`define SUT_SR_TX_DONE     2

// Reset values
`define SUT_RST_MODE       8'h00
`define SUT_RST_BITRATE    8'h03
`define SUT_RST_CTRL       8'h00
`define SUT_RST_TXDATA     8'hFF
`define SUT_RST_RXDATA     8'h00

// Character length and last bit index
`define SUT_CHAR_BITS      8
`define SUT_MSB_IDX        3'h7

`endif

/* File: sut_pkg.sv */
package sut_pkg;

    typedef enum logic [1:0]
    {
        SUT_FRM_IDLE  = 2'b00,
        SUT_FRM_SHIFT = 2'b01
    } sut_frame_t;

    typedef logic [7:0] sut_byte_t;

endpackage

/* File: sut_sck_gen.sv */
`timescale 1ns/10ps
`include "sut_defs.svh"

module sut_sck_gen
    import sut_pkg::*;
#(
    parameter int DIV_W = 8
)
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ext_mode,
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] half_div,
    input  wire logic             sck_in,
    output logic                  sck_out,
    output logic                  fall_ev,
    output logic                  rise_ev
);

    logic             sync0_r;
    logic             sync1_r;
    logic             prev_r;
    logic             sck_r;
    logic [DIV_W-1:0] cnt_r;
    logic             fall_r;
    logic             rise_r;
    logic             sync0_nxt;
    logic             sync1_nxt;
    logic             prev_nxt;
    logic             sck_nxt;
    logic [DIV_W-1:0] cnt_nxt;
    logic             fall_nxt;
    logic             rise_nxt;

    always_comb
    begin
        sync0_nxt = sck_in;
        sync1_nxt = sync0_r;
        prev_nxt  = sync1_r;
        sck_nxt   = sck_r;
        cnt_nxt   = cnt_r;
        fall_nxt  = 1'b0;
        rise_nxt  = 1'b0;
        if (ext_mode)
        begin
            // Edges of the synchronised external clock
            sck_nxt  = 1'b1;
            cnt_nxt  = '0;
            fall_nxt = prev_r & ~sync1_r;
            rise_nxt = ~prev_r & sync1_r;
        end
        else if (sck_r && !run)
        begin
            // Idle high between characters
            cnt_nxt = '0;
        end
        else if (cnt_r == half_div)
        begin
            cnt_nxt  = '0;
            sck_nxt  = ~sck_r;
            fall_nxt = sck_r;
            rise_nxt = ~sck_r;
        end
        else
        begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync0_r <= 1'b1;
            sync1_r <= 1'b1;
            prev_r  <= 1'b1;
            sck_r   <= 1'b1;
            cnt_r   <= '0;
            fall_r  <= 1'b0;
            rise_r  <= 1'b0;
        end
        else
        begin
            sync0_r <= sync0_nxt;
            sync1_r <= sync1_nxt;
            prev_r  <= prev_nxt;
            sck_r   <= sck_nxt;
            cnt_r   <= cnt_nxt;
            fall_r  <= fall_nxt;
            rise_r  <= rise_nxt;
        end
    end

    assign sck_out = sck_r;
    assign fall_ev = fall_r;
    assign rise_ev = rise_r;

endmodule

/* File: sut_serial.sv */
`timescale 1ns/10ps
`include "sut_defs.svh"

// Notes on behaviour
// - clearing tx_on sets tx_empty_flag and clears the transmit shift register
// - clearing rx_on keeps receive flags and received data unchanged
// - a dma write of transmit data clears tx_empty_flag by itself
// - parity or framing error blocks rx_full_flag and all transfers
// - while overrun_flag is set no new character starts
// - each reception aligns to the serial clock and restarts its bit count
// - received bits enter the shift register LSB first
// - finished character loads only if rx_full_flag is clear, else overrun
// - rx_full_flag with rx_irq_en raises the receive-full request
// - overrun_flag with rx_irq_en raises the receive-error request
// - a dma read of received data clears rx_full_flag by itself
// - characters are eight data bits, no parity or extra bit
// - internal clock gives eight pulses per character, high when idle
// - data changes on falling clock, valid on rising, LSB first, MSB held
// - MSB out with tx_empty_flag set raises tx_done_flag and its request
module sut_serial
    import sut_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        dma_access,
    input  wire logic        sck_in,
    input  wire logic        rxd,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             sck_out,
    output logic             sck_oe,
    output logic             txd,
    output logic             tx_empty_irq,
    output logic             rx_full_irq,
    output logic             rx_error_irq,
    output logic             tx_done_irq
);

    sut_byte_t  mode_r,     mode_nxt;
    sut_byte_t  rate_r,     rate_nxt;
    sut_byte_t  ctrl_r,     ctrl_nxt;
    sut_byte_t  tdr_r,      tdr_nxt;
    sut_byte_t  rdr_r,      rdr_nxt;
    sut_byte_t  tsr_r,      tsr_nxt;
    sut_byte_t  rsr_r,      rsr_nxt;
    logic       tx_empty_r, tx_empty_nxt;
    logic       rx_full_r,  rx_full_nxt;
    logic       ovr_r,      ovr_nxt;
    logic       fer_r,      fer_nxt;
    logic       per_r,      per_nxt;
    logic       tx_done_r,  tx_done_nxt;
    logic       tx_ld_r,    tx_ld_nxt;
    logic       frm_tx_r,   frm_tx_nxt;
    logic       frm_rx_r,   frm_rx_nxt;
    sut_frame_t frm_r,      frm_nxt;
    logic [2:0] bit_r,      bit_nxt;
    logic       txd_r,      txd_nxt;
    logic       rxd0_r,     rxd0_nxt;
    logic       rxd1_r,     rxd1_nxt;
    logic [31:0] prdata_r,  prdata_nxt;
    logic       pready_r,   pready_nxt;
    logic       pslverr_r,  pslverr_nxt;
    logic       oe_r,       oe_nxt;
    logic       txe_irq_r,  txe_irq_nxt;
    logic       rxf_irq_r,  rxf_irq_nxt;
    logic       rxe_irq_r,  rxe_irq_nxt;
    logic       txd_irq_r,  txd_irq_nxt;
    logic       acc;
    logic       wr;
    logic       blocked;
    logic       start_ok;
    logic       run;
    logic       fall_ev;
    logic       rise_ev;
    sut_byte_t  rx_word;

    sut_sck_gen #(
        .DIV_W    (8)
    ) u_sck (
        .pclk     (pclk),
        .presetn  (presetn),
        .ext_mode (ctrl_r[`SUT_CR_CLK_EXT]),
        .run      (run),
        .half_div (rate_r),
        .sck_in   (sck_in),
        .sck_out  (sck_out),
        .fall_ev  (fall_ev),
        .rise_ev  (rise_ev)
    );

    always_comb
    begin
        mode_nxt     = mode_r;
        rate_nxt     = rate_r;
        ctrl_nxt     = ctrl_r;
        tdr_nxt      = tdr_r;
        rdr_nxt      = rdr_r;
        tsr_nxt      = tsr_r;
        rsr_nxt      = rsr_r;
        tx_empty_nxt = tx_empty_r;
        rx_full_nxt  = rx_full_r;
        ovr_nxt      = ovr_r;
        fer_nxt      = fer_r;
        per_nxt      = per_r;
        tx_done_nxt  = tx_done_r;
        tx_ld_nxt    = tx_ld_r;
        frm_tx_nxt   = frm_tx_r;
        frm_rx_nxt   = frm_rx_r;
        frm_nxt      = frm_r;
        bit_nxt      = bit_r;
        txd_nxt      = txd_r;
        rxd0_nxt     = rxd;
        rxd1_nxt     = rxd0_r;
        rx_word      = {rxd1_r, rsr_r[7:1]};
        acc          = psel && penable && pready_r;
        wr           = acc && pwrite;
        blocked      = ovr_r || fer_r || per_r;
        start_ok     = !blocked && ((ctrl_r[`SUT_CR_TX_ON] && tx_ld_r)
                       || (ctrl_r[`SUT_CR_RX_ON] && !ctrl_r[`SUT_CR_TX_ON]));
        run          = (frm_r == SUT_FRM_SHIFT) || start_ok;

        // APB: setup cycle prepares the answer, access cycle completes it
        pready_nxt  = psel && !penable;
        pslverr_nxt = 1'b0;
        prdata_nxt  = 32'h0000_0000;
        if (psel && !penable)
        begin
            if (paddr == `SUT_OFS_MODE)
                prdata_nxt = {24'h00_0000, mode_r};
            else if (paddr == `SUT_OFS_BITRATE)
                prdata_nxt = {24'h00_0000, rate_r};
            else if (paddr == `SUT_OFS_CTRL)
                prdata_nxt = {24'h00_0000, ctrl_r};
            else if (paddr == `SUT_OFS_TXDATA)
                prdata_nxt = {24'h00_0000, tdr_r};
            else if (paddr == `SUT_OFS_STATUS)
                prdata_nxt = {24'h00_0000, tx_empty_r, rx_full_r, ovr_r, fer_r, per_r, tx_done_r, 2'b00};
            else if (paddr == `SUT_OFS_RXDATA)
                prdata_nxt = {24'h00_0000, rdr_r};
            else
                pslverr_nxt = 1'b1;
        end

        if (wr)
        begin
            if (paddr == `SUT_OFS_MODE)
                mode_nxt = pwdata[7:0];
            else if (paddr == `SUT_OFS_BITRATE)
                rate_nxt = pwdata[7:0];
            else if (paddr == `SUT_OFS_CTRL)
                ctrl_nxt = pwdata[7:0];
            else if (paddr == `SUT_OFS_TXDATA)
            begin
                tdr_nxt = pwdata[7:0];
                if (dma_access)
                    tx_empty_nxt = 1'b0;
            end
            else if (paddr == `SUT_OFS_STATUS)
            begin
                tx_empty_nxt = tx_empty_r & pwdata[`SUT_SR_TX_EMPTY];
                rx_full_nxt  = rx_full_r  & pwdata[`SUT_SR_RX_FULL];
                ovr_nxt      = ovr_r      & pwdata[`SUT_SR_OVERRUN];
                fer_nxt      = fer_r      & pwdata[`SUT_SR_FRAMING];
                per_nxt      = per_r      & pwdata[`SUT_SR_PARITY];
                tx_done_nxt  = tx_done_r  & pwdata[`SUT_SR_TX_DONE];
            end
        end
        if (acc && !pwrite && dma_access && paddr == `SUT_OFS_RXDATA)
            rx_full_nxt = 1'b0;

        // Move fresh data into the shift register
        if (ctrl_r[`SUT_CR_TX_ON] && !tx_empty_r && !tx_ld_r && !blocked)
        begin
            tsr_nxt      = tdr_r;
            tx_ld_nxt    = 1'b1;
            tx_empty_nxt = 1'b1;
            tx_done_nxt  = 1'b0;
        end

        if (fall_ev)
        begin
            if (frm_r == SUT_FRM_IDLE && start_ok)
            begin
                frm_nxt    = SUT_FRM_SHIFT;
                bit_nxt    = 3'h0;
                rsr_nxt    = 8'h00;
                frm_tx_nxt = tx_ld_r;
                frm_rx_nxt = ctrl_r[`SUT_CR_RX_ON];
                if (tx_ld_r)
                    txd_nxt = tsr_r[0];
            end
            else if (frm_r == SUT_FRM_SHIFT)
            begin
                if (frm_tx_r)
                    txd_nxt = tsr_r[bit_r];
                if (bit_r == `SUT_MSB_IDX && frm_tx_r && tx_empty_r)
                    tx_done_nxt = 1'b1;
            end
        end

        if (rise_ev && frm_r == SUT_FRM_SHIFT)
        begin
            if (frm_rx_r)
                rsr_nxt = rx_word;
            bit_nxt = bit_r + 3'h1;
            if (bit_r == `SUT_MSB_IDX)
            begin
                frm_nxt = SUT_FRM_IDLE;
                bit_nxt = 3'h0;
                if (frm_tx_r)
                    tx_ld_nxt = 1'b0;
                if (frm_rx_r && !fer_r && !per_r)
                begin
                    if (!rx_full_r)
                    begin
                        rdr_nxt     = rx_word;
                        rx_full_nxt = 1'b1;
                    end
                    else
                    begin
                        ovr_nxt = 1'b1;
                    end
                end
            end
        end

        // Disabling the transmitter wins over the empty flag, shift register, load flag and transmit frame flag
        if (wr && paddr == `SUT_OFS_CTRL && !pwdata[`SUT_CR_TX_ON])
        begin
            tx_empty_nxt = 1'b1;
            tsr_nxt      = 8'h00;
            tx_ld_nxt    = 1'b0;
            frm_tx_nxt   = 1'b0;
        end
        // Clearing rx_on touches no receive flag or data

        oe_nxt      = !ctrl_nxt[`SUT_CR_CLK_EXT];
        txe_irq_nxt = tx_empty_nxt && ctrl_nxt[`SUT_CR_TXE_IE];
        rxf_irq_nxt = rx_full_nxt && ctrl_nxt[`SUT_CR_RX_IE];
        rxe_irq_nxt = (ovr_nxt || fer_nxt || per_nxt) && ctrl_nxt[`SUT_CR_RX_IE];
        txd_irq_nxt = tx_done_nxt && ctrl_nxt[`SUT_CR_TXD_IE];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_r     <= `SUT_RST_MODE;
            rate_r     <= `SUT_RST_BITRATE;
            ctrl_r     <= `SUT_RST_CTRL;
            tdr_r      <= `SUT_RST_TXDATA;
            rdr_r      <= `SUT_RST_RXDATA;
            tsr_r      <= 8'h00;
            rsr_r      <= 8'h00;
            tx_empty_r <= 1'b1;
            rx_full_r  <= 1'b0;
            ovr_r      <= 1'b0;
            fer_r      <= 1'b0;
            per_r      <= 1'b0;
            tx_done_r  <= 1'b1;
            tx_ld_r    <= 1'b0;
            frm_tx_r   <= 1'b0;
            frm_rx_r   <= 1'b0;
            frm_r      <= SUT_FRM_IDLE;
            bit_r      <= 3'h0;
            txd_r      <= 1'b1;
            rxd0_r     <= 1'b1;
            rxd1_r     <= 1'b1;
            prdata_r   <= 32'h0000_0000;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            oe_r       <= 1'b1;
            txe_irq_r  <= 1'b0;
            rxf_irq_r  <= 1'b0;
            rxe_irq_r  <= 1'b0;
            txd_irq_r  <= 1'b0;
        end
        else
        begin
            mode_r     <= mode_nxt;
            rate_r     <= rate_nxt;
            ctrl_r     <= ctrl_nxt;
            tdr_r      <= tdr_nxt;
            rdr_r      <= rdr_nxt;
            tsr_r      <= tsr_nxt;
            rsr_r      <= rsr_nxt;
            tx_empty_r <= tx_empty_nxt;
            rx_full_r  <= rx_full_nxt;
            ovr_r      <= ovr_nxt;
            fer_r      <= fer_nxt;
            per_r      <= per_nxt;
            tx_done_r  <= tx_done_nxt;
            tx_ld_r    <= tx_ld_nxt;
            frm_tx_r   <= frm_tx_nxt;
            frm_rx_r   <= frm_rx_nxt;
            frm_r      <= frm_nxt;
            bit_r      <= bit_nxt;
            txd_r      <= txd_nxt;
            rxd0_r     <= rxd0_nxt;
            rxd1_r     <= rxd1_nxt;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
            oe_r       <= oe_nxt;
            txe_irq_r  <= txe_irq_nxt;
            rxf_irq_r  <= rxf_irq_nxt;
            rxe_irq_r  <= rxe_irq_nxt;
            txd_irq_r  <= txd_irq_nxt;
        end
    end

    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign sck_oe       = oe_r;
    assign txd          = txd_r;
    assign tx_empty_irq = txe_irq_r;
    assign rx_full_irq  = rxf_irq_r;
    assign rx_error_irq = rxe_irq_r;
    assign tx_done_irq  = txd_irq_r;

endmodule

/* File: sut_peer.sv */
`timescale 1ns/10ps
module sut_peer
(
    input  wire logic       sck,
    input  wire logic       txd,
    input  wire logic [7:0] send_byte,
    output logic            rxd,
    output logic [7:0]      got_byte,
    output int              n_got
);
    logic [7:0] sh;
    int         idx = 0;
    logic       armed = 1'b0;
    initial
    begin
        rxd = 1'b1;
        got_byte = 8'h00;
        n_got = 0;
    end
    // Launch on falling clock, LSB first
    // Rise out of the unknown start state is not a bit
    always @(negedge sck)
    begin
        armed = 1'b1;
        rxd <= send_byte[idx[2:0]];
    end
    always @(posedge sck)
    begin
        if (armed)
        begin
            sh = {txd, sh[7:1]};
            idx = idx + 1;
            if (idx == 8)
            begin
                idx = 0;
                got_byte <= sh;
                n_got <= n_got + 1;
                // Line no longer held once the hold time runs out
                fork
                    begin
                        #360;
                        if (sck)
                            rxd <= ~rxd;
                    end
                join_none
            end
        end
    end
endmodule

/* File: sut_chk.sv */
`timescale 1ns/10ps
`include "sut_defs.svh"
module sut_chk
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        dma_access,
    input wire logic        pready,
    input wire logic        sck_out,
    input wire logic        sck_oe,
    input wire logic        txd,
    input wire logic        tx_empty_irq,
    input wire logic        rx_full_irq,
    input wire logic        rx_error_irq,
    input wire logic        tx_done_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc_w;
    logic acc_r;
    assign acc_w = psel && penable && pready && pwrite;
    assign acc_r = psel && penable && pready && !pwrite;

    a_pready_one_cycle: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single access cycle");
    a_tx_off_empty: assert property (acc_w && paddr == `SUT_OFS_CTRL && !pwdata[5] && pwdata[7] |-> ##[1:3] tx_empty_irq)
        else $error("tx_on cleared but empty request missing");
    a_dma_write_clears: assert property (acc_w && dma_access && paddr == `SUT_OFS_TXDATA && tx_empty_irq |-> ##[1:2] !tx_empty_irq)
        else $error("dma write did not clear empty flag");
    a_overrun_no_frame: assert property (rx_error_irq && sck_oe |=> !$fell(sck_out))
        else $error("frame started during overrun");
    a_error_req_held: assert property (rx_error_irq && !(acc_w && (paddr == `SUT_OFS_STATUS
        || paddr == `SUT_OFS_CTRL)) |=> rx_error_irq)
        else $error("error request dropped without a register write");
    a_dma_read_clears: assert property (acc_r && dma_access && paddr == `SUT_OFS_RXDATA && rx_full_irq |-> ##[1:2] !rx_full_irq)
        else $error("dma read did not clear full flag");
    a_sck_low_bounded: assert property (sck_oe && $fell(sck_out) |-> ##[1:256] sck_out)
        else $error("serial clock stuck low");
    a_txd_on_fall: assert property (sck_oe && $changed(txd) |-> !$past(sck_out))
        else $error("txd changed while clock high");
    a_txd_held_end: assert property ($rose(tx_done_irq) |=> $stable(txd) [*6])
        else $error("txd not held after last bit");

    cover property ($rose(tx_done_irq));
    cover property ($rose(rx_error_irq));
    cover property (acc_w && dma_access);
endmodule
bind sut_serial sut_chk u_chk
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .dma_access, .pready,
    .sck_out, .sck_oe, .txd, .tx_empty_irq, .rx_full_irq, .rx_error_irq, .tx_done_irq
);

/* File: sync_serial_txrx_tb_top.sv */
`timescale 1ns/10ps
`include "sut_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module sync_serial_txrx_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, dma_access, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, sck_out, sck_oe, txd, rxd, sck_pin, ext_sck;
    logic        tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq;
    logic [7:0]  send_byte, got_byte;
    int          n_got, g0, r0, mismatches, n_tests;
    int          n_rise = 0;

    assign sck_pin = sck_oe ? sck_out : ext_sck;
    always @(posedge sck_pin) n_rise++;

    sut_serial DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .dma_access(dma_access), .sck_in(sck_pin), .rxd(rxd),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_out(sck_out), .sck_oe(sck_oe),
        .txd(txd), .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq),
        .rx_error_irq(rx_error_irq), .tx_done_irq(tx_done_irq));
    sut_peer u_peer (.sck(sck_pin), .txd(txd), .send_byte(send_byte), .rxd(rxd),
        .got_byte(got_byte), .n_got(n_got));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic dm);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        dma_access <= dm;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            mismatches++;
            $display("MISMATCH t=%0t no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        dma_access <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask
    task automatic rdx(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0, 1'b0);
        `CHK(rd, {24'h000000, e})
    endtask
    task automatic wait_got(input int prev);
        int n;
        n = 0;
        while (n_got == prev && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        if (n_got == prev)
        begin
            mismatches++;
            $display("MISMATCH t=%0t no character at peer", $time);
        end
        repeat (12) @(posedge pclk);
    endtask

    task automatic t_reset;
        rdx(`SUT_OFS_STATUS, 8'h84);
        rdx(`SUT_OFS_CTRL, 8'h00);
        rdx(`SUT_OFS_BITRATE, 8'h03);
        rdx(`SUT_OFS_TXDATA, 8'hFF);
        rdx(`SUT_OFS_RXDATA, 8'h00);
        apb(1'b0, 12'h018, 32'h0, 1'b0);
        `CHK(err, 1'b1)
        `CHK(sck_out, 1'b1)
        `CHK(sck_oe, 1'b1)
        $display("t_reset done");
    endtask
    task automatic t_tx;
        wr(`SUT_OFS_MODE, 32'h00);
        wr(`SUT_OFS_BITRATE, 32'h03);
        wr(`SUT_OFS_CTRL, 32'h00);
        repeat (8) @(posedge pclk);
        wr(`SUT_OFS_CTRL, 32'h24);
        r0 = n_rise;
        g0 = n_got;
        rdx(`SUT_OFS_STATUS, 8'h84);
        wr(`SUT_OFS_TXDATA, 32'h5A);
        wr(`SUT_OFS_STATUS, 32'h7F);
        wait_got(g0);
        `CHK(got_byte, 8'h5A)
        `CHK(n_rise - r0, 8)
        `CHK(txd, 1'b0)
        `CHK(tx_done_irq, 1'b1)
        rdx(`SUT_OFS_STATUS, 8'h84);
        $display("t_tx done");
    endtask
    task automatic t_dma_tx;
        wr(`SUT_OFS_CTRL, 32'hA0);
        wr(`SUT_OFS_STATUS, 32'hFF);
        `CHK(tx_empty_irq, 1'b1)
        g0 = n_got;
        apb(1'b1, `SUT_OFS_TXDATA, 32'hC6, 1'b1);
        wait_got(g0);
        `CHK(got_byte, 8'hC6)
        $display("t_dma_tx done");
    endtask
    task automatic t_rx;
        wr(`SUT_OFS_CTRL, 32'h00);
        send_byte = 8'h3C;
        g0 = n_got;
        wr(`SUT_OFS_CTRL, 32'h50);
        wait_got(g0);
        send_byte = 8'hC3;
        `CHK(rx_full_irq, 1'b1)
        rdx(`SUT_OFS_RXDATA, 8'h3C);
        wait_got(g0 + 1);
        `CHK(rx_error_irq, 1'b1)
        rdx(`SUT_OFS_RXDATA, 8'h3C);
        rdx(`SUT_OFS_STATUS, 8'hE4);
        r0 = n_rise;
        repeat (100) @(posedge pclk);
        `CHK(n_rise, r0)
        wr(`SUT_OFS_CTRL, 32'h40);
        rdx(`SUT_OFS_STATUS, 8'hE4);
        rdx(`SUT_OFS_RXDATA, 8'h3C);
        wr(`SUT_OFS_STATUS, 32'hDF);
        rdx(`SUT_OFS_STATUS, 8'hC4);
        apb(1'b0, `SUT_OFS_RXDATA, 32'h0, 1'b1);
        rdx(`SUT_OFS_STATUS, 8'h84);
        `CHK(rx_full_irq, 1'b0)
        $display("t_rx done");
    endtask
    task automatic t_abort;
        g0 = n_got;
        wr(`SUT_OFS_CTRL, 32'hA0);
        wr(`SUT_OFS_TXDATA, 32'h81);
        wr(`SUT_OFS_STATUS, 32'h7F);
        wr(`SUT_OFS_TXDATA, 32'h18);
        wr(`SUT_OFS_STATUS, 32'h7F);
        `CHK(tx_empty_irq, 1'b0)
        wr(`SUT_OFS_CTRL, 32'h80);
        apb(1'b0, `SUT_OFS_STATUS, 32'h0, 1'b0);
        `CHK(rd[7], 1'b1)
        `CHK(tx_empty_irq, 1'b1)
        wait_got(g0);
        $display("t_abort done");
    endtask
    task automatic ext_byte;
        repeat (8)
        begin
            ext_sck <= 1'b0;
            repeat (4) @(posedge pclk);
            ext_sck <= 1'b1;
            repeat (4) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
    endtask
    task automatic t_ext;
        send_byte = 8'hA5;
        wr(`SUT_OFS_CTRL, 32'h02);
        repeat (8) @(posedge pclk);
        `CHK(sck_oe, 1'b0)
        wr(`SUT_OFS_CTRL, 32'h12);
        ext_byte();
        rdx(`SUT_OFS_STATUS, 8'hC0);
        apb(1'b0, `SUT_OFS_RXDATA, 32'h0, 1'b1);
        `CHK(rd, 32'h0000_00A5)
        send_byte = 8'h69;
        ext_byte();
        rdx(`SUT_OFS_STATUS, 8'hC0);
        rdx(`SUT_OFS_RXDATA, 8'h69);
        $display("t_ext done");
    endtask

    task automatic close_out;
        $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (6000) @(posedge pclk);
        mismatches++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        close_out();
    end
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        dma_access = 1'b0;
        presetn = 1'b0;
        send_byte = 8'hFF;
        ext_sck = 1'b1;
        mismatches = 0;
        n_tests = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_tx();
        t_dma_tx();
        t_rx();
        t_abort();
        t_ext();
        close_out();
    end
endmodule
